// ==== vms_consts.vh ====
`ifndef VMS_CONSTS_VH
`define VMS_CONSTS_VH
`define VMS_CODE_W 6
`define VMS_LVL_GND 2'h0
`define VMS_LVL_REF 2'h1
`define VMS_LVL_OPEN 2'h2
`define VMS_LVL_VCC 2'h3
`define VMS_BLANK_CYC 5'h18
`define VMS_FALL_EXTRA 2'h2
`define VMS_SOFT_DIV 2'h3
`define VMS_SLEW_DIV_DEF 16'h0032
`endif

// ==== vms_target_slew.v ====
`include "vms_consts.vh"
// codes are DAC counts: larger code means higher output voltage.
// the vid table and offset are mapped by the converter side.
module vms_target_slew #(
  parameter SLEW_DIV = `VMS_SLEW_DIV_DEF
) (
  core_clk,
  rst_n,
  run_control_n,
  susp_level,
  pulse_omit_level,
  offset_band_active,
  vid_code_bits,
  standby_code_lo,
  standby_code_hi,
  vid_target_code,
  susp_upper_code,
  susp_lower_code,
  undervoltage_trip,
  overvoltage_trip,
  thermal_trip,
  dac_code,
  offset_enable,
  skip_enable,
  upper_good_blank,
  output_good_flag,
  uv_check_enable,
  switching_enable,
  low_gate_drive,
  high_gate_drive,
  fault_latched,
  transition_busy
);
  input wire core_clk;
  input wire rst_n;
  input wire run_control_n;
  input wire [1:0] susp_level;
  input wire [1:0] pulse_omit_level;
  input wire offset_band_active;
  input wire [5:0] vid_code_bits;
  input wire [1:0] standby_code_lo;
  input wire [1:0] standby_code_hi;
  input wire [5:0] vid_target_code;
  input wire [5:0] susp_upper_code;
  input wire [5:0] susp_lower_code;
  input wire undervoltage_trip;
  input wire overvoltage_trip;
  input wire thermal_trip;
  output reg [5:0] dac_code;
  output reg offset_enable;
  output reg skip_enable;
  output reg upper_good_blank;
  output reg output_good_flag;
  output reg uv_check_enable;
  output reg switching_enable;
  output reg [1:0] low_gate_drive;
  output reg [1:0] high_gate_drive;
  output reg fault_latched;
  output wire transition_busy;

  localparam ST_OFF = 2'h0;
  localparam ST_RAMP = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_DOWN = 2'h3;

  // pins from outside: two flip-flops before use
  reg run_s1_reg, run_s2_reg;
  reg [1:0] sus_s1_reg, sus_s2_reg, omit_s1_reg, omit_s2_reg;
  reg ofs_s1_reg, ofs_s2_reg;
  reg [5:0] vid_s1_reg, vid_s2_reg;
  reg [1:0] slo_s1_reg, slo_s2_reg, shi_s1_reg, shi_s2_reg;
  reg uv_s1_reg, uv_s2_reg, ov_s1_reg, ov_s2_reg, th_s1_reg, th_s2_reg;

  reg [15:0] div_cnt_reg;
  reg slew_tick;
  reg [1:0] quarter_reg;
  reg [1:0] state_reg;
  reg [1:0] fall_wait_reg;
  reg [4:0] blank_cnt_reg;
  reg blank_reg;
  reg susp_active_reg;
  reg [5:0] vid_smp_reg;
  reg [1:0] slo_smp_reg, shi_smp_reg;
  reg [5:0] target;
  reg susp_now;
  wire step_tick;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      sus_s1_reg <= 2'h0;
      sus_s2_reg <= 2'h0;
      omit_s1_reg <= 2'h0;
      omit_s2_reg <= 2'h0;
      ofs_s1_reg <= 1'b0;
      ofs_s2_reg <= 1'b0;
      vid_s1_reg <= 6'h00;
      vid_s2_reg <= 6'h00;
      slo_s1_reg <= 2'h0;
      slo_s2_reg <= 2'h0;
      shi_s1_reg <= 2'h0;
      shi_s2_reg <= 2'h0;
      uv_s1_reg <= 1'b0;
      uv_s2_reg <= 1'b0;
      ov_s1_reg <= 1'b0;
      ov_s2_reg <= 1'b0;
      th_s1_reg <= 1'b0;
      th_s2_reg <= 1'b0;
    end else begin
      run_s1_reg <= run_control_n;
      run_s2_reg <= run_s1_reg;
      sus_s1_reg <= susp_level;
      sus_s2_reg <= sus_s1_reg;
      omit_s1_reg <= pulse_omit_level;
      omit_s2_reg <= omit_s1_reg;
      ofs_s1_reg <= offset_band_active;
      ofs_s2_reg <= ofs_s1_reg;
      vid_s1_reg <= vid_code_bits;
      vid_s2_reg <= vid_s1_reg;
      slo_s1_reg <= standby_code_lo;
      slo_s2_reg <= slo_s1_reg;
      shi_s1_reg <= standby_code_hi;
      shi_s2_reg <= shi_s1_reg;
      uv_s1_reg <= undervoltage_trip;
      uv_s2_reg <= uv_s1_reg;
      ov_s1_reg <= overvoltage_trip;
      ov_s2_reg <= ov_s1_reg;
      th_s1_reg <= thermal_trip;
      th_s2_reg <= th_s1_reg;
    end
  end

  // run_control_n high means running
  wire running = run_s2_reg;

  // target mux: suspend code wins over vid in all modes
  // the converter-side tables share this clock, so they skip the sync
  always @* begin
    susp_now = (sus_s2_reg != `VMS_LVL_GND);
    if (sus_s2_reg == `VMS_LVL_REF)
      target = susp_upper_code;
    else if (susp_now)
      target = susp_lower_code;
    else
      target = vid_target_code;
  end

  // a new selection at the pins since the last step tick
  wire retarget = (vid_smp_reg != vid_s2_reg) ||
    (slo_smp_reg != slo_s2_reg) || (shi_smp_reg != shi_s2_reg) ||
    (susp_active_reg != susp_now);

  // ground and ref on the omit pin both select light-load skipping
  function omit_low;
    input [1:0] lvl;
    begin
      omit_low = (lvl == `VMS_LVL_GND) || (lvl == `VMS_LVL_REF);
    end
  endfunction

  // one code count toward ground, for falling moves and soft stop
  function [5:0] code_dec;
    input [5:0] code;
    begin
      code_dec = code - 6'h01;
    end
  endfunction

  // slew clock: one tick per SLEW_DIV core cycles
  always @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 16'h0000;
      slew_tick <= 1'b0;
    end else if (div_cnt_reg >= SLEW_DIV - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
      slew_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      slew_tick <= 1'b0;
    end
  end

  // free-running phase: the first soft step lands within four ticks
  always @(posedge core_clk) begin
    if (!rst_n)
      quarter_reg <= 2'h0;
    else if (slew_tick)
      quarter_reg <= quarter_reg + 2'h1;
  end

  // soft start and soft stop use every fourth slew tick
  assign step_tick = slew_tick &&
    (((state_reg == ST_RAMP) || (state_reg == ST_DOWN)) ?
     (quarter_reg == `VMS_SOFT_DIV) : 1'b1);

  assign transition_busy = (dac_code != target) || (blank_cnt_reg != 5'h00);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
      dac_code <= 6'h00;
      fault_latched <= 1'b0;
      fall_wait_reg <= 2'h0;
      blank_cnt_reg <= 5'h00;
      blank_reg <= 1'b1;
      susp_active_reg <= 1'b0;
      vid_smp_reg <= 6'h00;
      slo_smp_reg <= 2'h0;
      shi_smp_reg <= 2'h0;
    end else begin
      // fault latch cleared only by toggling run
      // set needs run high and clear needs run low, so they never meet
      if (!running)
        fault_latched <= 1'b0;
      else if (ov_s2_reg || th_s2_reg ||
               (uv_s2_reg && !blank_reg && state_reg == ST_RUN))
        fault_latched <= 1'b1;
      // sample at step rate so a soft ramp cannot skip a change
      if (step_tick) begin
        vid_smp_reg <= vid_s2_reg;
        slo_smp_reg <= slo_s2_reg;
        shi_smp_reg <= shi_s2_reg;
        susp_active_reg <= susp_now;
      end
      case (state_reg)
        ST_OFF: begin
          blank_reg <= 1'b1;
          if (running && !fault_latched) begin
            state_reg <= ST_RAMP;
            blank_cnt_reg <= `VMS_BLANK_CYC;
          end
        end
        ST_RAMP, ST_RUN: begin
          if (!running || fault_latched) begin
            state_reg <= ST_DOWN;
            blank_reg <= 1'b1;
          end else if (step_tick) begin
            if (dac_code < target) begin
              dac_code <= dac_code + 6'h01;
              fall_wait_reg <= 2'h0;
              blank_reg <= 1'b1;
              blank_cnt_reg <= `VMS_BLANK_CYC;
            end else if (dac_code > target) begin
              blank_reg <= 1'b1;
              blank_cnt_reg <= `VMS_BLANK_CYC;
              if (fall_wait_reg < `VMS_FALL_EXTRA)
                fall_wait_reg <= fall_wait_reg + 2'h1;
              else
                dac_code <= code_dec(dac_code);
            end else begin
              fall_wait_reg <= 2'h0;
              state_reg <= ST_RUN;
              // a fresh selection at rest restarts the full blanking window
              if (retarget) begin
                blank_reg <= 1'b1;
                blank_cnt_reg <= `VMS_BLANK_CYC;
              end else if (blank_cnt_reg != 5'h00) begin
                blank_cnt_reg <= blank_cnt_reg - 5'h01;
                if (blank_cnt_reg == 5'h01)
                  blank_reg <= 1'b0;
              end else begin
                blank_reg <= 1'b0;
              end
            end
          end
        end
        ST_DOWN: begin
          blank_reg <= 1'b1;
          if (step_tick) begin
            if (dac_code != 6'h00)
              dac_code <= code_dec(dac_code);
            else
              state_reg <= ST_OFF;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  // mode and gate outputs registered
  always @(posedge core_clk) begin
    if (!rst_n) begin
      offset_enable <= 1'b0;
      skip_enable <= 1'b0;
      upper_good_blank <= 1'b0;
      output_good_flag <= 1'b0;
      uv_check_enable <= 1'b0;
      switching_enable <= 1'b0;
      low_gate_drive <= 2'h3;
      high_gate_drive <= 2'h0;
    end else begin
      offset_enable <= running && !susp_now && ofs_s2_reg;
      skip_enable <= omit_low(omit_s2_reg);
      upper_good_blank <= omit_low(omit_s2_reg);
      output_good_flag <= (state_reg == ST_RUN) && !blank_reg &&
                          !fault_latched;
      uv_check_enable <= (state_reg == ST_RUN) && !blank_reg;
      // stay switching through soft stop until code reaches zero
      switching_enable <= (state_reg != ST_OFF);
      low_gate_drive <= (state_reg == ST_OFF) ? 2'h3 : 2'h0;
      high_gate_drive <= 2'h0;
    end
  end
endmodule // vms_target_slew

// ==== vms_target_slew_monitor.sv ====
module vms_target_slew_monitor #(
  parameter SLEW_DIV = 16'h0032
) (
  input wire core_clk,
  input wire rst_n,
  input wire run_control_n,
  input wire [1:0] susp_level,
  input wire [1:0] pulse_omit_level,
  input wire [5:0] dac_code,
  input wire offset_enable,
  input wire skip_enable,
  input wire upper_good_blank,
  input wire output_good_flag,
  input wire uv_check_enable,
  input wire switching_enable,
  input wire [1:0] low_gate_drive,
  input wire [1:0] high_gate_drive,
  input wire fault_latched,
  input wire transition_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles since the code last moved, saturating
  logic [11:0] quiet_reg;
  always @(posedge core_clk) begin
    if (!rst_n || $changed(dac_code)) quiet_reg <= 12'h000;
    else if (quiet_reg != 12'hFFF) quiet_reg <= quiet_reg + 12'h001;
  end
  sequence code_moved;
    $changed(dac_code);
  endsequence
  sequence code_rested;
    $stable(dac_code)[*3];
  endsequence
  gate_park_a: assert property (!switching_enable |->
    low_gate_drive == 2'h3 && high_gate_drive == 2'h0) else $error("gates");
  step_size_a: assert property (code_moved |-> dac_code ==
    $past(dac_code) + 6'h01 || dac_code == $past(dac_code) - 6'h01)
    else $error("step size");
  step_rate_a: assert property (code_moved |=> code_rested)
    else $error("step rate");
  good_wait_a: assert property ($rose(output_good_flag) |->
    quiet_reg >= 23 * SLEW_DIV) else $error("good too early");
  fault_good_a: assert property (fault_latched |->
    ##[0:2] !output_good_flag) else $error("good in fault");
  fault_down_a: assert property (fault_latched && $past(fault_latched) &&
    $changed(dac_code) |-> dac_code < $past(dac_code))
    else $error("fault code rose");
  fault_hold_a: assert property ((fault_latched && run_control_n)[*4]
    |=> fault_latched) else $error("fault cleared");
  skip_on_a: assert property ((pulse_omit_level <= 2'h1)[*8] |->
    skip_enable && upper_good_blank) else $error("skip");
  susp_offs_a: assert property ((susp_level != 2'h0)[*8] |->
    !offset_enable) else $error("offset in suspend");
  uv_blank_a: assert property (quiet_reg < 23 * SLEW_DIV |->
    !uv_check_enable && !output_good_flag) else $error("uv not blanked");
endmodule // vms_target_slew_monitor

bind vms_target_slew vms_target_slew_monitor #(.SLEW_DIV(SLEW_DIV)) u_mon (
  .core_clk, .rst_n, .run_control_n, .susp_level, .pulse_omit_level,
  .dac_code, .offset_enable, .skip_enable, .upper_good_blank,
  .output_good_flag, .uv_check_enable, .switching_enable, .low_gate_drive,
  .high_gate_drive, .fault_latched, .transition_busy);

// ==== vms_host_model.sv ====
module vms_host_model (
  input wire logic core_clk,
  input wire logic run_req,
  input wire logic [5:0] vid_req,
  input wire logic [1:0] susp_req,
  input wire logic [1:0] skip_req,
  output logic run_control_n = 1'b0,
  output logic [5:0] vid_code_bits = 6'h0A,
  output logic [1:0] susp_level = 2'h0,
  output logic [1:0] pulse_omit_level = 2'h3,
  output logic [1:0] standby_code_lo,
  output logic [1:0] standby_code_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  assign standby_code_lo = 2'h2; // strapped, never moved
  assign standby_code_hi = 2'h1;
  always @(posedge core_clk) begin
    run_control_n <= run_req;
    vid_code_bits <= vid_req; // all six bits on one edge
    susp_level <= susp_req; // ground, open, or pull-up to ref or supply
    pulse_omit_level <= skip_req;
  end
endmodule // vms_host_model

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic run_req = 1'b0;
  logic [5:0] vid_req = 6'h0A;
  logic [1:0] susp_req = 2'h0;
  logic [1:0] skip_req = 2'h3;
  logic offset_band_active = 1'b0;
  logic [2:0] trip = 3'h0;
  logic [5:0] susp_upper_code = 6'h28;
  logic [5:0] susp_lower_code = 6'h14;
  wire run_control_n, offset_enable, skip_enable, upper_good_blank;
  wire output_good_flag, uv_check_enable, switching_enable;
  wire fault_latched, transition_busy;
  wire [5:0] vid_code_bits, dac_code, vid_target_code;
  wire [1:0] susp_level, pulse_omit_level, standby_code_lo, standby_code_hi;
  wire [1:0] low_gate_drive, high_gate_drive;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int c, old, n;
  localparam int DIV = 4;
  // converter-side table: inverted, larger vid code means lower DAC code and lower volts
  assign vid_target_code = 6'h3F - vid_code_bits;
  always #20 core_clk = ~core_clk;
  vms_host_model host (.core_clk, .run_req, .vid_req, .susp_req, .skip_req,
    .run_control_n, .vid_code_bits, .susp_level, .pulse_omit_level,
    .standby_code_lo, .standby_code_hi);
  vms_target_slew #(.SLEW_DIV(16'(DIV))) dut (.core_clk, .rst_n,
    .run_control_n, .susp_level, .pulse_omit_level, .offset_band_active,
    .vid_code_bits, .standby_code_lo, .standby_code_hi, .vid_target_code,
    .susp_upper_code, .susp_lower_code, .undervoltage_trip(trip[0]),
    .overvoltage_trip(trip[1]), .thermal_trip(trip[2]), .dac_code,
    .offset_enable, .skip_enable, .upper_good_blank, .output_good_flag,
    .uv_check_enable, .switching_enable, .low_gate_drive, .high_gate_drive,
    .fault_latched, .transition_busy);
  function automatic int want();
    if (susp_req == 2'h0) return 63 - vid_req;
    return (susp_req == 2'h1) ? susp_upper_code : susp_lower_code;
  endfunction
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // idle also waits for the blanking count to run out
  task automatic wait_code(input int e, input bit idle);
    c = 0;
    while ((dac_code !== 6'(e) || (idle && transition_busy !== 1'b0)) &&
           c < 5000) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    if (c >= 5000) begin
      fail_count++;
      $display("mismatch at %0t: wait for code %0d timed out", $time, e);
    end
  endtask
  // lo is the nominal slew time, with slack for sync and tick phase
  task automatic timed(input int e, input int step, input int extra);
    n = (e > old) ? e - old : old - e;
    old = e;
    wait_code(e, 1'b0);
    chk(dac_code, 6'(e));
    n = (n - 1) * step + extra;
    chk(6'(c >= n && c <= n + 3 * step + 12), 1);
    wait_code(e, 1'b1);
    chk(6'(c >= 24 * DIV && c <= 28 * DIV), 1);
  endtask
  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h9e940d98));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(dac_code, 6'h00);
    chk({low_gate_drive, high_gate_drive, 1'b0, switching_enable}, 6'h30);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      run_req <= 1'b1;
      old = 0;
      timed(want(), 4 * DIV, 0);
      repeat (110) @(posedge core_clk);
      chk({4'h0, output_good_flag, switching_enable}, 6'h03);
      if (k == 3) break;
      trip <= 3'h1 << k;
      repeat (10) @(posedge core_clk);
      trip <= 3'h0;
      wait_code(0, 1'b0);
      repeat (30) @(posedge core_clk);
      chk({fault_latched, low_gate_drive, high_gate_drive, 1'b0}, 6'h38);
      run_req <= 1'b0;
      repeat (10) @(posedge core_clk);
    end
    $display("test startup and faults done");
    repeat (8) begin
      @(posedge core_clk);
      n = $urandom;
      if (6'(n) == vid_req) n = n + 1;
      vid_req <= 6'(n);
      @(posedge core_clk);
      n = want();
      timed(n, DIV, (n < old) ? 2 * DIV : 0);
    end
    $display("test vid moves done");
    @(posedge core_clk);
    offset_band_active <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk({5'h0, offset_enable}, 6'h01);
    for (int s = 1; s < 4; s++) begin
      @(posedge core_clk);
      susp_req <= 2'(s);
      repeat (2) @(posedge core_clk);
      wait_code(want(), 1'b1);
      chk(dac_code, 6'(want()));
      chk({5'h0, offset_enable}, 6'h00);
    end
    $display("test suspend done");
    for (int l = 0; l < 4; l++) begin
      @(posedge core_clk);
      skip_req <= 2'(l);
      repeat (14) @(posedge core_clk);
      chk({4'h0, skip_enable, upper_good_blank}, (l < 2) ? 6'h03 : 6'h00);
    end
    $display("test pulse omit done");
    summarize();
  end
endmodule // testbench
